// file: logic/pdma_cfg.svh
// offsets, field positions, reset values and codes of the peripheral dma channels
// assumes inclusion by pdma_pkg and the channel control module
// What this block does
// - zero count with reload: pointer takes reload
// - zero count with reload: count takes reload
// - zero count, zero reload: no more transfers
// - count reload clears the reload register
// - reload value is sixteen low bits
// - error clear command clears fault, resumes
// - disable command stops channel transfers
// - enable command starts channel transfers
// - size field selects byte, halfword, word
// - enabled bit follows enable and disable
// - set-mask writes of one set mask
// - clear-mask writes of one clear mask
// - fault flag holds errors since last clear
// - complete flag when count and reload zero
// - reload-zero flag while reload is zero
// - selector codes map to handshake lines
// - lowest numbered requesting channel wins
// - failed memory access sets fault, stops
// - pointer advances one item per transfer
`ifndef PDMA_CFG_SVH
`define PDMA_CFG_SVH
`define PDMA_NUM_CH 7
`define PDMA_NUM_HS 14
`define PDMA_CH_STRIDE_LSB 6
`define PDMA_OFS_PTR 6'h00
`define PDMA_OFS_PSEL 6'h04
`define PDMA_OFS_REM 6'h08
`define PDMA_OFS_PRLD 6'h0c
`define PDMA_OFS_CRLD 6'h10
`define PDMA_OFS_CMD 6'h14
`define PDMA_OFS_WCFG 6'h18
`define PDMA_OFS_STATE 6'h1c
`define PDMA_OFS_IMSET 6'h20
`define PDMA_OFS_IMCLR 6'h24
`define PDMA_OFS_IMST 6'h28
`define PDMA_OFS_IFLG 6'h2c
`define PDMA_CMD_EN 0
`define PDMA_CMD_DIS 1
`define PDMA_CMD_ERROR_CLEAR_CMD 8
`define PDMA_FLG_RCZ 0
`define PDMA_FLG_TRC 1
`define PDMA_FLG_TRANSFER_FAULT_FLAG 2
`define PDMA_SZ_BYTE 2'h0
`define PDMA_SZ_HALF 2'h1
`define PDMA_SZ_WORD 2'h2
`define PDMA_PID_CONV 4'h0
`define PDMA_PID_RX_HI 4'h6
`define PDMA_PID_TX_HI 4'hd
`define PDMA_RST_WORD 32'h0000_0000
`endif

// file: logic/pdma_pkg.sv
// types shared by the peripheral dma channel control
// assumes pdma_cfg.svh is on the include path
`include "pdma_cfg.svh"
package pdma_pkg;
  typedef logic [3:0] pdma_pid_t;
  typedef enum logic {PDMA_IDLE, PDMA_MEM} pdma_xs_t;
  typedef struct packed {
    logic [31:0] ptr;
    logic [31:0] prld;
    logic [15:0] rem;
    logic [15:0] crld;
    pdma_pid_t psel;
    logic [1:0] size;
    logic en;
    logic fault;
    logic [2:0] mask;
  } pdma_ch_t;
endpackage

// file: logic/pdma_ctrl.sv
// channel control, status and arbitration of the peripheral dma
// assumes an ahb-lite master, handshakes and memory bus on clk
//
// The AHB-Lite slave port is built in; reads take one wait state and hresp is tied low.
`timescale 1ns/1ns
`default_nettype none
`include "pdma_cfg.svh"
module pdma_ctrl #(
  parameter int NUM_CH = `PDMA_NUM_CH,
  parameter int NUM_HS = `PDMA_NUM_HS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_HS-1:0] hs_req,
  input wire logic [31:0] hs_rdata,
  output logic [NUM_HS-1:0] hs_ack,
  output logic [31:0] hs_wdata,
  output pdma_pkg::pdma_pid_t hs_sel,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_write,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  output var logic [NUM_CH-1:0] irq
);
  import pdma_pkg::*;
  localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  typedef struct packed {
    pdma_ch_t [NUM_CH-1:0] ch;
    pdma_xs_t xs;
    logic [CW-1:0] cur;
    logic [31:0] maddr;
    logic mwr;
    logic [1:0] msz;
    logic [31:0] mwd;
    pdma_pid_t msel;
    logic [NUM_HS-1:0] hs_ack;
    logic [31:0] hs_wd;
    logic dp_v;
    logic dp_wr;
    logic rd_wait;
    logic [11:0] dp_addr;
    logic [31:0] hrdata;
  } pdma_st_t;

  pdma_st_t st_ff;
  pdma_st_t nxt_st;
  logic [NUM_CH-1:0] req;
  logic gnt;
  logic [CW-1:0] gidx;
  logic wr;
  logic [5:0] wc;
  logic [5:0] wo;
  logic [31:0] rdat;

  // flags: fault, complete, reload-zero
  function automatic logic [2:0] flags(input pdma_ch_t c);
    flags = '0;
    flags[`PDMA_FLG_TRANSFER_FAULT_FLAG] = c.fault;
    flags[`PDMA_FLG_TRC] = (c.rem == 16'h0000) && (c.crld == 16'h0000);
    flags[`PDMA_FLG_RCZ] = (c.crld == 16'h0000);
  endfunction

  // item width in bytes; reserved code treated as word
  function automatic logic [31:0] item_bytes(input logic [1:0] sz);
    unique case (sz)
      `PDMA_SZ_BYTE: item_bytes = 32'h0000_0001;
      `PDMA_SZ_HALF: item_bytes = 32'h0000_0002;
      default: item_bytes = 32'h0000_0004;
    endcase
  endfunction

  function automatic logic pid_ok(input pdma_pid_t p);
    pid_ok = (p <= `PDMA_PID_TX_HI);
  endfunction

  // codes up to the last receive code move peripheral data to memory
  function automatic logic pid_rx(input pdma_pid_t p);
    pid_rx = (p <= `PDMA_PID_RX_HI);
  endfunction

  function automatic logic [CW-1:0] lowest(input logic [NUM_CH-1:0] v);
    lowest = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = CW'(i);
      end
    end
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.hs_ack = '0;
    irq = '0;
    req = '0;
    rdat = '0;
    wr = st_ff.dp_v && st_ff.dp_wr;
    wc = st_ff.dp_addr[11:6];
    wo = st_ff.dp_addr[5:0];
    // bus data phase: read value from the latched address
    if (wc < 6'(NUM_CH)) begin
      unique case (wo)
        `PDMA_OFS_PTR: rdat = st_ff.ch[wc[CW-1:0]].ptr;
        `PDMA_OFS_PSEL: rdat = {28'h000_0000, st_ff.ch[wc[CW-1:0]].psel};
        `PDMA_OFS_REM: rdat = {16'h0000, st_ff.ch[wc[CW-1:0]].rem};
        `PDMA_OFS_PRLD: rdat = st_ff.ch[wc[CW-1:0]].prld;
        `PDMA_OFS_CRLD: rdat = {16'h0000, st_ff.ch[wc[CW-1:0]].crld};
        `PDMA_OFS_WCFG: rdat = {30'h0000_0000, st_ff.ch[wc[CW-1:0]].size};
        `PDMA_OFS_STATE: rdat = {31'h0000_0000, st_ff.ch[wc[CW-1:0]].en};
        `PDMA_OFS_IMST: rdat = {29'h0000_0000, st_ff.ch[wc[CW-1:0]].mask};
        `PDMA_OFS_IFLG: rdat = {29'h0000_0000, flags(st_ff.ch[wc[CW-1:0]])};
        default: rdat = `PDMA_RST_WORD;
      endcase
    end
    if (st_ff.rd_wait) begin
      nxt_st.hrdata = rdat;
      nxt_st.rd_wait = 1'b0;
    end
    // address phase
    if (hready) begin
      nxt_st.dp_v = hsel && htrans[1];
      nxt_st.dp_wr = hwrite;
      nxt_st.dp_addr = haddr[11:0];
      nxt_st.rd_wait = hsel && htrans[1] && !hwrite;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      // software writes
      if (wr && wc == 6'(i)) begin
        unique case (wo)
          `PDMA_OFS_PTR: nxt_st.ch[i].ptr = hwdata;
          `PDMA_OFS_PSEL: nxt_st.ch[i].psel = hwdata[3:0];
          `PDMA_OFS_REM: nxt_st.ch[i].rem = hwdata[15:0];
          `PDMA_OFS_PRLD: nxt_st.ch[i].prld = hwdata;
          `PDMA_OFS_CRLD: nxt_st.ch[i].crld = hwdata[15:0];
          `PDMA_OFS_CMD: begin
            if (hwdata[`PDMA_CMD_EN]) begin
              nxt_st.ch[i].en = 1'b1;
            end
            if (hwdata[`PDMA_CMD_DIS]) begin
              nxt_st.ch[i].en = 1'b0;
            end
            if (hwdata[`PDMA_CMD_ERROR_CLEAR_CMD]) begin
              nxt_st.ch[i].fault = 1'b0;
            end
          end
          `PDMA_OFS_WCFG: nxt_st.ch[i].size = hwdata[1:0];
          `PDMA_OFS_IMSET: nxt_st.ch[i].mask = st_ff.ch[i].mask | hwdata[2:0];
          `PDMA_OFS_IMCLR: nxt_st.ch[i].mask = st_ff.ch[i].mask & ~hwdata[2:0];
          default: begin
          end
        endcase
      end
      // end of a memory access; a fault set wins over a clear
      if (st_ff.xs == PDMA_MEM && st_ff.cur == CW'(i) && mem_ack) begin
        if (mem_err) begin
          nxt_st.ch[i].fault = 1'b1;
        end else begin
          nxt_st.ch[i].ptr = st_ff.ch[i].ptr + item_bytes(st_ff.ch[i].size);
          if (st_ff.ch[i].rem != 16'h0000) begin
            nxt_st.ch[i].rem = st_ff.ch[i].rem - 16'h0001;
          end
        end
      end
      // reload once the count has run out
      if (st_ff.ch[i].rem == 16'h0000 && st_ff.ch[i].crld != 16'h0000) begin
        nxt_st.ch[i].ptr = st_ff.ch[i].prld;
        nxt_st.ch[i].rem = st_ff.ch[i].crld;
        nxt_st.ch[i].crld = 16'h0000;
      end
      // request: enabled, no fault, items left, valid selector asking
      req[i] = st_ff.ch[i].en && !st_ff.ch[i].fault
        && st_ff.ch[i].rem != 16'h0000
        && pid_ok(st_ff.ch[i].psel) && hs_req[st_ff.ch[i].psel];
      irq[i] = |(flags(st_ff.ch[i]) & st_ff.ch[i].mask);
    end
    gnt = (st_ff.xs == PDMA_IDLE) && (|req);
    gidx = lowest(req);
    unique case (st_ff.xs)
      PDMA_IDLE: begin
        if (gnt) begin
          nxt_st.xs = PDMA_MEM;
          nxt_st.cur = gidx;
          nxt_st.maddr = st_ff.ch[gidx].ptr;
          nxt_st.mwr = pid_rx(st_ff.ch[gidx].psel);
          nxt_st.msz = st_ff.ch[gidx].size;
          nxt_st.mwd = hs_rdata;
          nxt_st.msel = st_ff.ch[gidx].psel;
        end
      end
      PDMA_MEM: begin
        if (mem_ack) begin
          nxt_st.xs = PDMA_IDLE;
          if (!mem_err) begin
            nxt_st.hs_ack[st_ff.msel] = 1'b1;
            if (!st_ff.mwr) begin
              nxt_st.hs_wd = mem_rdata;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        st_ff.ch[i].psel <= 4'(i);
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = !st_ff.rd_wait;
  assign hresp = 1'b0;
  assign hrdata = st_ff.hrdata;
  assign hs_ack = st_ff.hs_ack;
  assign hs_wdata = st_ff.hs_wd;
  assign hs_sel = st_ff.msel;
  assign mem_req = (st_ff.xs == PDMA_MEM);
  assign mem_addr = st_ff.maddr;
  assign mem_write = st_ff.mwr;
  assign mem_size = st_ff.msz;
  assign mem_wdata = st_ff.mwd;

  // checks on channel 0 and the arbiter
  logic wr0;
  logic reload0;
  logic ack0;
  logic [NUM_CH-1:0] lowmask;
  assign wr0 = wr && wc == 6'h00;
  assign reload0 = st_ff.ch[0].rem == 16'h0000 && st_ff.ch[0].crld != 16'h0000;
  assign ack0 = st_ff.xs == PDMA_MEM && st_ff.cur == '0 && mem_ack;
  assign lowmask = NUM_CH'((1 << gidx) - 1);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_reload_ptr: assert property (reload0 |=> st_ff.ch[0].ptr == $past(st_ff.ch[0].prld))
    else $error("pointer not reloaded");
  a_reload_count: assert property (reload0 |=> st_ff.ch[0].rem == $past(st_ff.ch[0].crld))
    else $error("count not reloaded");
  a_no_more_xfer: assert property (st_ff.ch[0].rem == 16'h0000 && st_ff.ch[0].crld == 16'h0000
    |-> !req[0] ##1 (st_ff.ch[0].rem == 16'h0000 || $past(wr0)))
    else $error("transfer after count ran out");
  a_reload_clear: assert property (reload0 |=> st_ff.ch[0].crld == 16'h0000)
    else $error("reload register not cleared");
  a_reload_field: assert property (wr0 && wo == `PDMA_OFS_CRLD && !reload0
    |=> st_ff.ch[0].crld == $past(hwdata[15:0]))
    else $error("reload field mismatch");
  a_fault_clear: assert property (wr0 && wo == `PDMA_OFS_CMD && hwdata[8] && !(ack0 && mem_err)
    |=> !st_ff.ch[0].fault)
    else $error("fault not cleared");
  a_disable_cmd: assert property (wr0 && wo == `PDMA_OFS_CMD && hwdata[1] |=> !st_ff.ch[0].en)
    else $error("disable ignored");
  a_enable_cmd: assert property (wr0 && wo == `PDMA_OFS_CMD && hwdata[0] && !hwdata[1]
    |=> st_ff.ch[0].en ##0 (!$past(st_ff.ch[0].en) || st_ff.ch[0].en))
    else $error("enable ignored");
  a_size_pass: assert property (gnt |=> mem_req && mem_size == $past(st_ff.ch[gidx].size))
    else $error("item size not passed");
  a_mask_set: assert property (wr0 && wo == `PDMA_OFS_IMSET
    |=> st_ff.ch[0].mask == ($past(st_ff.ch[0].mask) | $past(hwdata[2:0])))
    else $error("mask not set");
  a_mask_clear: assert property (wr0 && wo == `PDMA_OFS_IMCLR
    |=> st_ff.ch[0].mask == ($past(st_ff.ch[0].mask) & ~$past(hwdata[2:0])))
    else $error("mask not cleared");
  a_fault_stop: assert property (ack0 && mem_err |=> st_ff.ch[0].fault && !req[0])
    else $error("error did not stop channel");
  a_flag_read: assert property (st_ff.rd_wait && wc == 6'h00 && wo == `PDMA_OFS_IFLG
    |=> hrdata[1] == $past(st_ff.ch[0].rem == 16'h0000 && st_ff.ch[0].crld == 16'h0000)
    && hrdata[0] == $past(st_ff.ch[0].crld == 16'h0000))
    else $error("flag read mismatch");
  a_pid_valid: assert property (gnt |=> hs_sel <= `PDMA_PID_TX_HI
    && mem_write == (hs_sel <= `PDMA_PID_RX_HI))
    else $error("bad selector granted");
  a_lowest_win: assert property (gnt |-> (req & lowmask) == '0 && req[gidx])
    else $error("arbiter skipped lower channel");
  a_ptr_step: assert property (ack0 && !mem_err && !reload0
    |=> st_ff.ch[0].ptr == $past(st_ff.ch[0].ptr) + item_bytes($past(st_ff.ch[0].size)))
    else $error("pointer did not advance");
  a_irq_fault: assert property ($rose(st_ff.ch[0].fault) && st_ff.ch[0].mask[2] |-> irq[0])
    else $error("fault interrupt missing");

  c_grant: cover property (gnt ##1 mem_req [*2] ##1 !mem_req);
  c_reload: cover property (ack0 && !mem_err ##1 reload0);
  c_error: cover property (ack0 && mem_err);
  c_read: cover property (st_ff.rd_wait ##1 hreadyout);
endmodule
`default_nettype wire

// file: verif/pdma_mem_model.sv
// memory bus responder for the peripheral dma channel control
// assumes the mem_* request and acknowledge pair of pdma_ctrl on one clock
`timescale 1ns/1ns
`default_nettype none
module pdma_mem_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] wait_cycles,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic mem_err
);
  logic [3:0] cnt_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 4'h0;
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req && !mem_ack && cnt_ff >= wait_cycles) begin
      // upper half of the address space is unmapped and fails
      cnt_ff <= 4'h0;
      mem_ack <= 1'b1;
      mem_err <= mem_addr[31];
      mem_rdata <= mem_addr ^ 32'h5a5a_5a5a;
    end else begin
      // read data outside an answer keeps changing
      cnt_ff <= (mem_req && !mem_ack) ? cnt_ff + 4'h1 : 4'h0;
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the peripheral dma channel control
// assumes pdma_pkg and pdma_ctrl are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pdma_pkg::*;
  logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, mem_req, mem_write, mem_ack, mem_err;
  logic [1:0] htrans, mem_size;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, hs_rdata, hs_wdata, mem_addr, mem_wdata, mem_rdata, exp_wd;
  logic [13:0] hs_req, hs_ack;
  logic [6:0] irq;
  logic [3:0] wait_cycles;
  pdma_pid_t hs_sel;
  int errors, total_checks, cycles;
  logic [34:0] acc_q[$];
  assign hready = hreadyout;
  pdma_ctrl u_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .hs_req(hs_req), .hs_rdata(hs_rdata), .hs_ack(hs_ack), .hs_wdata(hs_wdata), .hs_sel(hs_sel),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_write(mem_write), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err), .irq(irq));
  pdma_mem_model u_mem (.clk(clk), .arst_n(arst_n), .mem_req(mem_req), .mem_addr(mem_addr),
    .wait_cycles(wait_cycles), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // memory traffic log and handshake data check
  always @(posedge clk) begin
    cycles++;
    if (|hs_ack && hs_sel > 4'h6) chk(hs_wdata, exp_wd);
    if (|hs_ack) chk({18'h0_0000, hs_ack}, 32'h1 << hs_sel);
    if (mem_req && mem_ack) begin
      acc_q.push_back({mem_write, mem_size, mem_addr});
      exp_wd = mem_rdata;
      if (mem_write) chk(mem_wdata, hs_rdata);
    end
    // ceiling on run length, checked last so nothing follows the close
    if (cycles >= 4000) begin
      errors++;
      close_out;
    end
  end
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    // address phase held until hready is seen high at a rising edge
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    // data phase held until hready is seen high again; read data taken there
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask
  task automatic cfg(input logic [11:0] b, input logic [31:0] sel, sz, ptr, rem);
    wr(b + 12'h004, sel);
    wr(b + 12'h018, sz);
    wr(b, ptr);
    wr(b + 12'h008, rem);
  endtask
  task automatic wait_acc(input int n);
    int k;
    k = 0;
    while (acc_q.size() < n && k < 300) begin
      @(posedge clk);
      k++;
    end
    repeat (12) @(posedge clk);
  endtask
  task automatic chk_acc(input logic [34:0] exp);
    logic [34:0] e;
    e = (acc_q.size() > 0) ? acc_q.pop_front() : 35'h7_ffff_ffff;
    chk(e[31:0], exp[31:0]);
    chk({29'h0000_0000, e[34:32]}, {29'h0000_0000, exp[34:32]});
  endtask
  task automatic t_reset;
    rc(12'h010, 8'h00);
    rc(12'h01c, 8'h00);
    rc(12'h028, 8'h00);
    rc(12'h02c, 8'h03);
    rc(12'h014, 8'h00);
    rc(12'h044, 8'h01);
    rc(12'h1c0, 8'h00);
    chk({25'h000_0000, irq}, 8'h00);
  endtask
  task automatic t_field;
    wr(12'h148, 8'h05);
    wr(12'h150, 32'habcd_1234);
    rc(12'h150, 16'h1234);
    rc(12'h16c, 8'h00);
  endtask
  task automatic t_enable;
    wr(12'h014, 8'h01);
    rc(12'h01c, 8'h01);
    wr(12'h014, 8'h00);
    rc(12'h01c, 8'h01);
    wr(12'h014, 8'h02);
    rc(12'h01c, 8'h00);
    wr(12'h014, 8'h01);
    wr(12'h014, 8'h03);
    rc(12'h01c, 8'h00);
  endtask
  task automatic t_mask;
    wr(12'h020, 8'h05);
    rc(12'h028, 8'h05);
    chk({25'h000_0000, irq}, 8'h01);
    wr(12'h020, 8'h00);
    rc(12'h028, 8'h05);
    wr(12'h024, 8'h01);
    rc(12'h028, 8'h04);
    chk({25'h000_0000, irq}, 8'h00);
    wr(12'h024, 8'h00);
    rc(12'h028, 8'h04);
  endtask
  task automatic t_reload;
    wait_cycles <= 4'h3;
    cfg(12'h000, 8'h08, 8'h01, 16'h0100, 8'h02);
    wr(12'h00c, 16'h0200);
    wr(12'h010, 8'h01);
    wr(12'h014, 8'h01);
    hs_req <= 14'h0100;
    wait_acc(3);
    chk_acc({3'h1, 32'h0000_0100});
    chk_acc({3'h1, 32'h0000_0102});
    chk_acc({3'h1, 32'h0000_0200});
    chk(acc_q.size(), 8'h00);
    rc(12'h000, 16'h0202);
    rc(12'h010, 8'h00);
    rc(12'h02c, 8'h03);
  endtask
  task automatic t_priority;
    wait_cycles <= 4'h0;
    hs_rdata <= 32'h1357_9bdf;
    cfg(12'h040, 8'h00, 8'h00, 16'h0300, 8'h01);
    cfg(12'h080, 8'h03, 8'h02, 16'h0400, 8'h01);
    cfg(12'h0c0, 8'h0f, 8'h02, 16'h0600, 8'h01);
    wr(12'h0d4, 8'h01);
    wr(12'h094, 8'h01);
    wr(12'h054, 8'h01);
    hs_req <= 14'h3fff;
    wait_acc(2);
    chk_acc({3'h4, 32'h0000_0300});
    chk_acc({3'h6, 32'h0000_0400});
    chk(acc_q.size(), 8'h00);
  endtask
  task automatic t_fault;
    // channel 0 is still enabled, so the failing access starts with the count write
    wr(12'h020, 8'h04);
    cfg(12'h000, 8'h09, 8'h02, 32'h8000_0000, 8'h02);
    wr(12'h014, 8'h01);
    wait_acc(1);
    chk_acc({3'h2, 32'h8000_0000});
    chk(acc_q.size(), 8'h00);
    rc(12'h02c, 8'h05);
    chk({25'h000_0000, irq}, 8'h01);
    rc(12'h000, 32'h8000_0000);
    wr(12'h014, 8'h00);
    rc(12'h02c, 8'h05);
    wr(12'h000, 16'h0500);
    wr(12'h014, 16'h0100);
    wait_acc(2);
    chk_acc({3'h2, 32'h0000_0500});
    chk_acc({3'h2, 32'h0000_0504});
    rc(12'h02c, 8'h03);
  endtask
  initial begin
    errors = 0;
    total_checks = 0;
    cycles = 0;
    arst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hs_req = 14'h0000;
    hs_rdata = 32'h0000_0000;
    wait_cycles = 4'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_field;
    t_enable;
    t_mask;
    t_reload;
    t_priority;
    t_fault;
    close_out;
  end
endmodule
`default_nettype wire
